// [logic/sprx_link_shift.sv]
// shift-clock domain: assembles eight bits of a frame
`timescale 1ns/1ps
module sprx_link_shift
  import sprx_pkg::*;
(
  input wire logic link_clk,
  input wire logic link_clear,
  input wire logic data_pin,
  output logic [CODE_BITS-1:0] word,
  output logic full
);

  logic [3:0] bit_cnt;
  wire logic last_bit = (bit_cnt == 4'(CODE_BITS - 1));

  // the link clock stops between frames, so the frame is closed by an
  // asynchronous clear that the device clock domain holds high
  always_ff @(posedge link_clk or posedge link_clear)
  begin
    if (link_clear)
    begin
      bit_cnt <= 4'h0;
      word <= '0;
      full <= 1'b0;
    end
    else if (!full) // clocks past the eighth are ignored
    begin
      word <= {word[CODE_BITS-2:0], data_pin}; // msb enters first
      bit_cnt <= bit_cnt + 4'h1;
      full <= last_bit;
    end
  end

endmodule // sprx_link_shift

// [logic/sprx_pkg.sv]
// constants, types and decode helpers for the serial phrase code receiver
// Function
// - host sends code MSB first; device assembles bits in that order
// - beyond eight shift clocks in a frame, extra clocks are ignored
// - zero is stop, 01..F7 user phrases, F8 upward test codes
// - up to 247 distinct user phrase selections are distinguished
// - user data bytes 007C8..2FFFC; 2FFFD..2FFFF reserved
// - build option picks two or three wire framing and clock rate
// - two wire mode uses data and shift clock; select held low
// - two wire start bit: data low at least 1 us opens frame
// - code latches on falling edge of eighth shift clock
// - without the device clock no code is acquired
// - two wire: new start before eighth clock restarts the frame
// - three wire mode frames with data, shift clock and select
// - three wire: select high before eighth clock cancels the frame
// - latch empty flag high when empty, high after reset
// - reset puts the receiver in standby and clears its state
// - stop code during playback halts output at latch edge
package sprx_pkg;

  // framing and clock build options
  localparam logic MODE_THREE_WIRE = 1'b0;
  localparam logic MODE_TWO_WIRE = 1'b1;
  localparam logic [1:0] CLK_OPT_4M = 2'h0;
  localparam logic [1:0] CLK_OPT_8M = 2'h1;
  localparam logic [1:0] CLK_OPT_16M = 2'h2;
  localparam int EXT_CLK_4M_KHZ = 4096;
  localparam int EXT_CLK_8M_KHZ = 8192;
  localparam int EXT_CLK_16M_KHZ = 16384;

  // timing
  localparam int START_WIDTH_NS = 1000;
  localparam int CLEAR_CYC = 3;
  localparam int CODE_BITS = 8;

  // code classes
  localparam logic [7:0] CODE_STOP = 8'h00;
  localparam logic [7:0] CODE_PHRASE_LAST = 8'hF7;
  localparam logic [7:0] CODE_TEST_FIRST = 8'hF8;
  localparam int PHRASE_COUNT = 247;

  // mask rom regions
  localparam logic [17:0] ROM_USER_FIRST = 18'h0_07C8;
  localparam logic [17:0] ROM_USER_LAST = 18'h2_FFFC;
  localparam logic [17:0] ROM_RESV_FIRST = 18'h2_FFFD;

  // received code with its class
  typedef struct packed {
    logic [7:0] value;
    logic is_stop;
    logic is_phrase;
    logic is_test;
  } sprx_code_t;

  // pin and link samples passed through the synchroniser
  typedef struct packed {
    logic done;
    logic sclk;
    logic data;
    logic sel_n;
  } sprx_sample_t;

  // clock rate of a build option in kHz
  function automatic int sprx_clk_khz(input logic [1:0] opt);
    case (opt)
      CLK_OPT_8M: sprx_clk_khz = EXT_CLK_8M_KHZ;
      CLK_OPT_16M: sprx_clk_khz = EXT_CLK_16M_KHZ;
      default: sprx_clk_khz = EXT_CLK_4M_KHZ;
    endcase
  endfunction

  // least start width in cycles, rounded up
  function automatic int sprx_start_cyc(input logic [1:0] opt);
    int c;
    c = (START_WIDTH_NS * sprx_clk_khz(opt) + 999_999) / 1_000_000;
    sprx_start_cyc = (c < 1) ? 1 : c;
  endfunction

  // classify a received code
  function automatic sprx_code_t sprx_classify(input logic [7:0] v);
    sprx_code_t r;
    r.value = v;
    r.is_stop = (v == CODE_STOP);
    r.is_test = (v >= CODE_TEST_FIRST);
    r.is_phrase = (v != CODE_STOP) && (v <= CODE_PHRASE_LAST);
    sprx_classify = r;
  endfunction

  // true when a rom byte address lies in the user data area
  function automatic logic sprx_rom_user(input logic [17:0] a);
    sprx_rom_user = (a >= ROM_USER_FIRST) && (a <= ROM_USER_LAST);
  endfunction

endpackage

// [logic/sprx_receiver.sv]
// serial phrase code receiver: framing, code latch and decode
`timescale 1ns/1ps
module sprx_receiver
  import sprx_pkg::*;
#(
  parameter logic MODE = MODE_TWO_WIRE,
  parameter logic [1:0] CLK_OPT = CLK_OPT_4M
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic shift_clk,
  input wire logic phrase_data_pin,
  input wire logic frame_select_n,
  input wire logic code_take,
  input wire logic playing,
  input wire logic [17:0] rom_addr,
  output sprx_code_t code,
  output logic code_valid,
  output logic stop_request,
  output logic code_latch_empty_flag,
  output logic frame_active,
  output logic standby,
  output logic rom_addr_user
);

  // start width in device clocks for the selected build option
  localparam int START_CYC = sprx_start_cyc(CLK_OPT);
  localparam logic [5:0] START_LAST = 6'(START_CYC - 1);
  localparam logic [1:0] CLEAR_LAST = 2'(CLEAR_CYC - 1);
  localparam sprx_sample_t SAMPLE_IDLE = '{done: 1'b0, sclk: 1'b1,
                                           data: 1'b1, sel_n: 1'b1};

  typedef enum logic [3:0] {
    ST_CLOSED = 4'b0001,
    ST_CLEAR = 4'b0010,
    ST_OPEN = 4'b0100,
    ST_RELEASE = 4'b1000
  } sprx_state_t;

  sprx_state_t state;
  sprx_state_t next_state;
  logic link_clear;
  logic [CODE_BITS-1:0] link_word;
  logic link_full;
  sprx_sample_t raw;
  sprx_sample_t smp;
  logic sclk_prev;
  logic data_prev;
  logic start_run;
  logic [5:0] start_cnt;
  logic [1:0] clear_cnt;

  // shift register on the link clock
  sprx_link_shift u_link (
    .link_clk(shift_clk),
    .link_clear(link_clear),
    .data_pin(phrase_data_pin),
    .word(link_word),
    .full(link_full)
  );

  // bring pins and the link full level into the device clock
  assign raw.done = link_full;
  assign raw.sclk = shift_clk;
  assign raw.data = phrase_data_pin;
  assign raw.sel_n = frame_select_n;

  sprx_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in(raw),
    .reset_val(SAMPLE_IDLE),
    .sync_out(smp)
  );

  // previous synchronised levels for edge detection
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sclk_prev <= 1'b1;
      data_prev <= 1'b1;
    end
    else
    begin
      sclk_prev <= smp.sclk;
      data_prev <= smp.data;
    end
  end

  // edges seen in the device clock domain
  wire logic sclk_fall = sclk_prev & ~smp.sclk;
  wire logic data_fall = data_prev & ~smp.data;
  wire logic two_wire = (MODE == MODE_TWO_WIRE); // select ignored in two wire
  wire logic sel_low = ~smp.sel_n;

  // start bit: data falls while the shift clock idles high, then stays low
  wire logic start_begin = two_wire & data_fall & smp.sclk;
  wire logic start_hold = smp.sclk & ~smp.data;
  wire logic start_done = start_run & start_hold & (start_cnt == START_LAST);

  // start width counter, counts device clocks only
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      start_run <= 1'b0;
      start_cnt <= 6'h00;
    end
    else if (start_begin)
    begin
      start_run <= (START_LAST != 6'h00);
      start_cnt <= 6'h01;
    end
    else if (start_run && (!start_hold || start_done))
    begin
      start_run <= 1'b0; // pulse too short or already accepted
      start_cnt <= 6'h00;
    end
    else if (start_run)
    begin
      start_cnt <= start_cnt + 6'h01;
    end
  end

  // a one cycle start pulse when the count is a single cycle
  wire logic start_ok = start_done | (start_begin & (START_LAST == 6'h00));

  // first falling edge after the eighth rising edge, with a full link word, closes the frame
  wire logic capture = (state == ST_OPEN) & sclk_fall & smp.done;

  // three wire frame gate
  wire logic three_open = ~two_wire & sel_low;
  wire logic three_cancel = ~two_wire & ~sel_low;

  // frame state transitions
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_CLOSED:
      begin
        if (two_wire && start_ok)
          next_state = ST_CLEAR;
        else if (three_open)
          next_state = ST_CLEAR;
      end
      ST_CLEAR:
      begin
        if (three_cancel)
          next_state = ST_CLOSED;
        else if (clear_cnt == CLEAR_LAST)
          next_state = ST_OPEN;
      end
      ST_OPEN:
      begin
        if (three_cancel)
          next_state = ST_CLOSED; // select rose early, frame dropped
        else if (two_wire && start_ok)
          next_state = ST_CLEAR; // restart discards the partial frame
        else if (capture)
          next_state = two_wire ? ST_CLOSED : ST_RELEASE;
      end
      ST_RELEASE:
      begin
        if (three_cancel)
          next_state = ST_CLOSED; // further clocks ignored till select rises
      end
      default:
      begin
        next_state = ST_CLOSED;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
      state <= ST_CLOSED;
    else
      state <= next_state;
  end

  // hold the link clear long enough for the full level to drain
  always_ff @(posedge clk)
  begin
    if (reset || state != ST_CLEAR)
      clear_cnt <= 2'h0;
    else
      clear_cnt <= clear_cnt + 2'h1;
  end

  // link stays cleared outside an open frame
  always_ff @(posedge clk)
  begin
    if (reset)
      link_clear <= 1'b1;
    else
      link_clear <= (next_state != ST_OPEN);
  end

  // frame activity indicator
  always_ff @(posedge clk)
  begin
    if (reset)
      frame_active <= 1'b0;
    else
      frame_active <= (next_state == ST_OPEN);
  end

  // code latch; link word is stable while the full level stands
  wire sprx_code_t new_code = sprx_classify(link_word);

  always_ff @(posedge clk)
  begin
    if (reset)
      code <= sprx_classify(CODE_STOP);
    else if (capture)
      code <= new_code;
  end

  // one cycle pulse when the latch loads
  always_ff @(posedge clk)
  begin
    if (reset)
      code_valid <= 1'b0;
    else
      code_valid <= capture;
  end

  // stop during playback halts output at the latch edge
  always_ff @(posedge clk)
  begin
    if (reset)
      stop_request <= 1'b0;
    else
      stop_request <= capture & new_code.is_stop & playing;
  end

  // empty flag: load wins over a take in the same cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      code_latch_empty_flag <= 1'b1;
    else if (capture)
      code_latch_empty_flag <= 1'b0;
    else if (code_take)
      code_latch_empty_flag <= 1'b1;
  end

  // standby while reset is held
  always_ff @(posedge clk)
  begin
    standby <= reset;
  end

  // rom address check for the user data area
  always_ff @(posedge clk)
  begin
    if (reset)
      rom_addr_user <= 1'b0;
    else
      rom_addr_user <= sprx_rom_user(rom_addr);
  end

endmodule // sprx_receiver

// [logic/sprx_sync.sv]
// two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
module sprx_sync
  import sprx_pkg::*;
#(
  parameter int WIDTH = 4
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_val,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stage1 <= reset_val;
      sync_out <= reset_val;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // sprx_sync

// [verif/sprx_host.sv]
// host model: shifts phrase codes in, msb first
`timescale 1ns/1ps
module sprx_host
(
  output logic shift_clk,
  output logic phrase_data_pin,
  output logic frame_select_n
);
  localparam int HALF_NS = 375; // each clock level over 350 ns
  // idle: clock stopped high, data pulled high, deselected
  initial
  begin
    shift_clk = 1'b1;
    phrase_data_pin = 1'b1;
    frame_select_n = 1'b1;
  end
  // one shift clock; data moves only while the clock is low
  task automatic pulse(input logic b);
    shift_clk = 1'b0;
    phrase_data_pin = b;
    #HALF_NS;
    shift_clk = 1'b1;
    #HALF_NS;
  endtask
  // select low and a start bit of 1.5 us with the clock high
  task automatic open_frame();
    phrase_data_pin = 1'b1;
    #HALF_NS;
    frame_select_n = 1'b0;
    phrase_data_pin = 1'b0;
    #1500;
  endtask
  // optional cut-off partial frame, then n clocks carrying v
  task automatic frame(input logic [7:0] v, input int n, input bit cut);
    if (cut)
    begin
      open_frame();
      for (int i = 7; i > 3; i--) pulse(~v[i]);
      frame_select_n = 1'b1;
      #2000;
    end
    open_frame();
    for (int i = 0; i < n; i++) pulse(i < 8 ? v[7-i] : 1'b1);
    // closing fall after the last rise; the first fall after the eighth rise latches the code, then idle high
    shift_clk = 1'b0;
    #HALF_NS;
    shift_clk = 1'b1;
    #1000;
    phrase_data_pin = 1'b1;
    frame_select_n = 1'b1;
  endtask
endmodule // sprx_host

// [verif/sprx_receiver_assertions.sv]
// port-level assertions for the serial phrase code receiver
`timescale 1ns/1ps
module sprx_receiver_assertions
  import sprx_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic code_take,
  input wire logic [17:0] rom_addr,
  input wire sprx_code_t code,
  input wire logic code_valid,
  input wire logic stop_request,
  input wire logic code_latch_empty_flag,
  input wire logic frame_active,
  input wire logic standby,
  input wire logic rom_addr_user
);
  a_valid_pulse: assert property (@(posedge clk) disable iff (reset)
    code_valid |=> !code_valid) else $error("code_valid over one cycle");
  a_load_fills: assert property (@(posedge clk) disable iff (reset)
    code_valid |-> !code_latch_empty_flag && !frame_active) else $error("load state wrong");
  a_code_class: assert property (@(posedge clk) disable iff (reset)
    code_valid |-> code.is_stop == (code.value == 8'h00) && code.is_test == (code.value >= 8'hF8)
      && code.is_phrase == (code.value != 8'h00 && code.value <= 8'hF7))
    else $error("code class wrong");
  a_code_held: assert property (@(posedge clk) disable iff (reset)
    !$stable(code) |-> code_valid) else $error("code changed without load");
  a_take_empties: assert property (@(posedge clk) disable iff (reset)
    code_take |=> code_latch_empty_flag || code_valid) else $error("take left latch full");
  a_empty_holds: assert property (@(posedge clk) disable iff (reset)
    !code_latch_empty_flag && !code_take |=> !code_latch_empty_flag) else $error("empty rose");
  a_stop_cause: assert property (@(posedge clk) disable iff (reset)
    stop_request |-> code_valid && code.is_stop) else $error("stray stop request");
  a_rom_window: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> rom_addr_user == ($past(rom_addr) >= ROM_USER_FIRST
      && $past(rom_addr) <= ROM_USER_LAST)) else $error("rom window wrong");
  a_reset_state: assert property (@(posedge clk)
    reset |=> code_latch_empty_flag && standby && !code_valid && !frame_active)
    else $error("reset state wrong");
endmodule // sprx_receiver_assertions

bind sprx_receiver sprx_receiver_assertions u_chk (.clk(clk), .reset(reset),
  .code_take(code_take), .rom_addr(rom_addr), .code(code), .code_valid(code_valid),
  .stop_request(stop_request), .code_latch_empty_flag(code_latch_empty_flag),
  .frame_active(frame_active), .standby(standby), .rom_addr_user(rom_addr_user));

// [verif/sprx_receiver_tb.sv]
// bench: a two wire and a three wire receiver fed by one host
`timescale 1ns/1ps
module sprx_receiver_tb
  import sprx_pkg::*;
;
  logic clk, reset, sclk, sdat, seln, take, play, v2, v3, s2, s3, e2, sb, u2;
  logic [17:0] addr;
  sprx_code_t c2, c3, g2, g3;
  int n2, n3, ns, err_count, num_checks;

  sprx_host u_host (.shift_clk(sclk), .phrase_data_pin(sdat), .frame_select_n(seln));
  sprx_receiver #(.MODE(MODE_TWO_WIRE), .CLK_OPT(CLK_OPT_4M)) u_dut (.clk(clk),
    .reset(reset), .shift_clk(sclk), .phrase_data_pin(sdat), .frame_select_n(1'b0),
    .code_take(take), .playing(play), .rom_addr(addr), .code(c2), .code_valid(v2),
    .stop_request(s2), .code_latch_empty_flag(e2), .frame_active(), .standby(sb),
    .rom_addr_user(u2));
  sprx_receiver #(.MODE(MODE_THREE_WIRE), .CLK_OPT(CLK_OPT_16M)) u_dut3 (.clk(clk),
    .reset(reset), .shift_clk(sclk), .phrase_data_pin(sdat), .frame_select_n(seln),
    .code_take(take), .playing(play), .rom_addr(addr), .code(c3), .code_valid(v3),
    .stop_request(s3), .code_latch_empty_flag(), .frame_active(), .standby(),
    .rom_addr_user());

  always #20 clk = ~clk;

  // keep the last code and count loads and stop pulses
  always @(posedge clk)
  begin
    if (v2 === 1'b1) g2 <= c2;
    if (v3 === 1'b1) g3 <= c3;
    n2 <= n2 + int'(v2 === 1'b1);
    n3 <= n3 + int'(v3 === 1'b1);
    ns <= ns + int'(s2 === 1'b1) + int'(s3 === 1'b1);
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // one frame to both receivers: exactly one load each, code as sent
  task automatic xfer(input logic [7:0] v, input int n, input bit cut);
    int b2, b3, i;
    b2 = n2;
    b3 = n3;
    u_host.frame(v, n, cut);
    for (i = 0; i < 50 && (n2 == b2 || n3 == b3); i++) @(posedge clk);
    if (i == 50)
    begin
      chk("load timeout", 0, 1);
      tally_and_finish();
    end
    else
    begin
      repeat (10) @(posedge clk);
      chk("two wire loads", b2 + 1, n2);
      chk("three wire loads", b3 + 1, n3);
      chk("two wire code", {24'h0, v}, {24'h0, g2.value});
      chk("three wire code", {24'h0, v}, {24'h0, g3.value});
    end
  endtask

  // ten clocks in one frame: only the first eight count
  task automatic t_long();
    xfer(8'h96, 10, 1'b0);
  endtask

  // a partial frame cut short, then a full one
  task automatic t_cut();
    xfer(8'h3C, 8, 1'b1);
  endtask

  // each code class and the edges of the phrase range
  task automatic t_codes();
    logic [7:0] tab [6] = '{8'h00, 8'h01, 8'hA5, 8'hF7, 8'hF8, 8'hFF};
    foreach (tab[k])
    begin
      xfer(tab[k], 8, 1'b0);
      chk("class", {tab[k] == 8'h00, tab[k] != 8'h00 && tab[k] <= 8'hF7, tab[k] >= 8'hF8},
        {g2.is_stop, g2.is_phrase, g2.is_test});
    end
    chk("idle stop", 0, ns);
  endtask

  // stop code while playing asks both receivers to stop
  task automatic t_stop();
    @(posedge clk);
    #2 play = 1'b1;
    xfer(8'h00, 8, 1'b0);
    chk("stop pulses", 2, ns);
    #2 play = 1'b0;
  endtask

  // consuming the latch raises the empty flag
  task automatic t_take();
    chk("latch full", 0, e2);
    @(posedge clk);
    #2 take = 1'b1;
    @(posedge clk);
    #2 take = 1'b0;
    chk("latch empty", 1, e2);
  endtask

  // rom addresses at both edges of the user area
  task automatic t_rom();
    logic [17:0] tab [4] = '{18'h0_07C7, 18'h0_07C8, 18'h2_FFFC, 18'h2_FFFD};
    foreach (tab[k])
    begin
      @(posedge clk);
      #2 addr = tab[k];
      @(posedge clk);
      #2 chk("rom user", tab[k] >= ROM_USER_FIRST && tab[k] <= ROM_USER_LAST, u2);
    end
  endtask

  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    take = 1'b0;
    play = 1'b0;
    addr = 18'h0_0000;
    {n2, n3, ns, err_count, num_checks} = '0;
    repeat (10) @(posedge clk);
    chk("reset empty", 1, e2);
    chk("reset standby", 1, sb);
    #2 reset = 1'b0;
    repeat (3) @(posedge clk);
    t_codes();
    t_long();
    t_cut();
    t_stop();
    t_take();
    t_rom();
    tally_and_finish();
  end
endmodule // sprx_receiver_tb
